// >>> hdl/cio_port_block.sv
`timescale 1ns/1ns
module cio_port_block #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic           sys_clk,
    input  wire logic           rstn,
    input  wire logic           clk_en,
    // host register port
    input  wire logic [5:0]     reg_addr,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    input  wire logic [7:0]     reg_wdata,
    output logic      [7:0]     reg_rdata,
    // host bus context
    input  wire logic [3:0]     bus_type,
    input  wire logic [15:0]    host_addr,
    input  wire logic           address_latch_strobe,
    input  wire logic           data_port_en,
    input  wire logic [7:0]     host_data_o,
    input  wire logic           host_data_oe,
    output logic      [7:0]     host_data_i,
    input  wire logic           peripheral_select_zero,
    input  wire logic           peripheral_select_one,
    input  wire logic           jtag_en,
    input  wire logic [7:0]     jtag_o,
    input  wire logic [7:0]     jtag_oe,
    // general logic array terms
    input  wire logic [4*W-1:0] logic_oe,
    input  wire logic [4*W-1:0] logic_out,
    // pins, ports A..D packed low to high
    input  wire logic [4*W-1:0] pin_i,
    output logic      [4*W-1:0] pin_o,
    output logic      [4*W-1:0] pin_oe,
    output logic      [4*W-1:0] pin_fast_slew
);
    ////////////////////////////////////////////////////////////////////////
    // configuration state
    logic [W-1:0] mode     [2];
    logic [W-1:0] dir      [4];
    logic [W-1:0] drv      [4];
    logic [W-1:0] dout     [4];
    logic [W-1:0] capt     [4];
    logic [7:0]   peripheral_mode_register;
    logic [W-1:0] port_mask [4];
    logic [1:0]   wr_port;
    logic [2:0]   wr_reg;

    assign wr_port = reg_addr[5:4];
    assign wr_reg  = reg_addr[2:0];
    assign port_mask[0] = 8'hFF;
    assign port_mask[1] = 8'hFF;
    assign port_mask[2] = 8'hFF;
    assign port_mask[3] = cio_pkg::PORT_D_MASK;

    // mode registers exist only on A and B
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode[0] <= cio_pkg::CFG_RESET;                                    // R13
            mode[1] <= cio_pkg::CFG_RESET;
        end else if (clk_en && reg_wr && wr_reg == cio_pkg::REG_MODE
                     && !wr_port[1]) begin
            mode[wr_port[0]] <= reg_wdata;                                    // R14 R24
        end
    end

    // direction, driver and output data, one set per port
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int p = 0; p < 4; p++) begin
                dir[p]  <= cio_pkg::CFG_RESET;                                // R13 R15
                drv[p]  <= cio_pkg::CFG_RESET;
                dout[p] <= cio_pkg::CFG_RESET;
            end
        end else if (clk_en && reg_wr) begin                                  // R24
            case (wr_reg)
                cio_pkg::REG_DIR:  dir[wr_port]  <= reg_wdata & port_mask[wr_port]; // R17
                cio_pkg::REG_DRV:  drv[wr_port]  <= reg_wdata & port_mask[wr_port];
                cio_pkg::REG_DOUT: dout[wr_port] <= reg_wdata & port_mask[wr_port]; // R22
                default: ;
            endcase
        end
    end

    // peripheral mode register, one per block
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            peripheral_mode_register <= cio_pkg::CFG_RESET;
        end else if (clk_en && reg_wr && wr_reg == cio_pkg::REG_PMODE) begin
            peripheral_mode_register <= reg_wdata;                            // R08
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched address routing per host bus flavour
    logic [W-1:0] addr_a;
    logic [W-1:0] addr_b;
    logic [W-1:0] addr_ok_a;
    logic [W-1:0] addr_ok_b;

    always_comb begin
        addr_a    = host_addr[7:0];
        addr_b    = host_addr[7:0];
        addr_ok_a = 8'hFF;
        addr_ok_b = 8'hFF;
        case (bus_type)
            cio_pkg::CIO_BUS_MUX: begin
                addr_ok_a = 8'hFF;                                            // R04
            end
            cio_pkg::CIO_BUS_PAGE: begin
                addr_b    = host_addr[15:8];                                  // R04
                addr_ok_a = 8'h00;
            end
            cio_pkg::CIO_BUS_NMUX: begin
                addr_ok_a = 8'h00;                                            // R03
            end
            default: begin
                addr_ok_a = 8'h00;
                addr_ok_b = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // per-port pin logic
    logic [W-1:0] sl_o   [4];
    logic [W-1:0] sl_oe  [4];
    logic [W-1:0] addr_sel [4];
    logic [W-1:0] od_sel [4];
    logic [W-1:0] slew   [4];

    always_comb begin
        // address output: logic enable or both dir and mode set
        addr_sel[0] = addr_ok_a & (logic_oe[W-1:0] | (dir[0] & mode[0]));    // R01
        addr_sel[1] = addr_ok_b & (logic_oe[2*W-1:W] | (dir[1] & mode[1]));  // R01
        addr_sel[2] = '0;
        addr_sel[3] = '0;
        od_sel[0] = drv[0] & cio_pkg::DRV_OD_MASK_AB;                         // R19
        od_sel[1] = drv[1] & cio_pkg::DRV_OD_MASK_AB;
        od_sel[2] = drv[2] & cio_pkg::DRV_OD_MASK_C;
        od_sel[3] = '0;
        slew[0]   = drv[0] & cio_pkg::DRV_SLEW_MASK_AB;                       // R20
        slew[1]   = drv[1] & cio_pkg::DRV_SLEW_MASK_AB;
        slew[2]   = '0;
        slew[3]   = drv[3] & cio_pkg::DRV_SLEW_MASK_D;
    end

    for (genvar p = 0; p < 4; p++) begin : g_port
        cio_pin_slice #(.W(W)) u_slice (
            .dir       (dir[p]),
            .logic_oe  (logic_oe[p*W +: W] & port_mask[p]),
            .addr_sel  (addr_sel[p]),
            .od_sel    (od_sel[p]),
            .dout      (dout[p]),
            .addr_val  (p == 0 ? addr_a : addr_b),
            .logic_out (logic_out[p*W +: W]),
            .next_o    (sl_o[p]),
            .next_oe   (sl_oe[p])
        );
        cio_capture #(.W(W)) u_capt (
            .sys_clk              (sys_clk),
            .rstn                 (rstn),
            .clk_en               (clk_en),
            .address_latch_strobe (address_latch_strobe),
            .pin_i                (pin_i[p*W +: W] & port_mask[p]),
            .captured             (capt[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // final pin muxing; port A overrides, port C shares with programming
    logic [4*W-1:0] next_o;
    logic [4*W-1:0] next_oe;
    logic           psel_any;

    assign psel_any = peripheral_select_zero | peripheral_select_one;

    always_comb begin
        for (int p = 0; p < 4; p++) begin
            next_o[p*W +: W]  = sl_o[p];
            next_oe[p*W +: W] = sl_oe[p] & port_mask[p];
        end
        if (data_port_en) begin                                               // R07
            next_o[W-1:0]  = host_data_o;
            next_oe[W-1:0] = {W{host_data_oe}};
        end else if (peripheral_mode_register[cio_pkg::PMODE_BIT]) begin      // R08
            next_o[W-1:0]  = host_data_o;
            next_oe[W-1:0] = {W{psel_any & host_data_oe}};                    // R09
        end
        if (jtag_en) begin                                                    // R10
            next_o[3*W-1:2*W]  = jtag_o;
            next_oe[3*W-1:2*W] = jtag_oe;
        end
    end

    // registered pin outputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_o         <= '0;
            pin_oe        <= '0;
            pin_fast_slew <= '0;
            host_data_i   <= 8'h00;
        end else if (clk_en) begin
            pin_o         <= next_o;
            pin_oe        <= next_oe;
            pin_fast_slew <= {slew[3], slew[2], slew[1], slew[0]};
            host_data_i   <= pin_i[W-1:0];  // data port and peripheral read path
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read, one cycle after the strobe
    logic [7:0] next_rdata;

    always_comb begin
        case (wr_reg)
            cio_pkg::REG_MODE:  next_rdata = wr_port[1] ? 8'h00 : mode[wr_port[0]]; // R11
            cio_pkg::REG_DIR:   next_rdata = dir[wr_port];
            cio_pkg::REG_DRV:   next_rdata = drv[wr_port];
            cio_pkg::REG_DIN:   next_rdata = pin_i[wr_port*W +: W] & port_mask[wr_port]; // R21
            cio_pkg::REG_DOUT:  next_rdata = dout[wr_port];                   // R22
            cio_pkg::REG_CAPT:  next_rdata = capt[wr_port];
            cio_pkg::REG_PMODE: next_rdata = peripheral_mode_register;
            default:            next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : cio_port_block

// >>> hdl/cio_pkg.sv
// Notes on behaviour
// R01: pin drives latched address when logic enable active, or direction and mode both 1.
// R02: host software sets direction and mode bits before using address output.
// R03: non-multiplexed 8-bit host: port B carries address 7:0, low nibble low pins.
// R04: multiplexed host: both ports give address 7:0; page variant puts 15:8 on B.
// R05: host boots internally before address-output pins feed external boot memory.
// R06: any pin can capture high address inputs on the address latch strobe.
// R07: port A as host data bus disables all general I/O on port A.
// R08: peripheral mode bit 7 set makes port A a bidirectional data buffer.
// R09: in peripheral mode port A floats unless a peripheral select is active.
// R10: port C pins shared between in-system programming and normal functions.
// R11: all configuration and data registers read and written at fixed offsets.
// R12: register bit n acts only on pin n of its port.
// R13: mode, direction and driver registers reset to zero.
// R14: mode bit 0 selects general I/O, 1 selects address output; A and B only.
// R15: direction bit 1 is output, 0 input; all pins start as inputs.
// R16: pin driver on when direction bit or logic enable is 1.
// R17: port D direction register keeps only its three low bits.
// R18: driver bit 1 on open-drain-capable pin selects open drain; default push-pull.
// R19: A,B: 7:4 open drain, 3:0 slew; C all open drain; D 2:0 slew.
// R20: driver bit 1 on slew-capable pin selects fast slew; default slow.
// R21: input-data read returns live pin levels, no storage.
// R22: output-data register holds written data, drives enabled pins, reads back.
// R23: host never sets direction 1 on a pin used as a logic input.
// R24: register writes take effect at the clock edge ending the write cycle.
package cio_pkg;
    // register index within a port's group
    localparam logic [2:0] REG_MODE  = 3'h0;
    localparam logic [2:0] REG_DIR   = 3'h1;
    localparam logic [2:0] REG_DRV   = 3'h2;
    localparam logic [2:0] REG_DIN   = 3'h3;
    localparam logic [2:0] REG_DOUT  = 3'h4;
    localparam logic [2:0] REG_CAPT  = 3'h5;
    localparam logic [2:0] REG_PMODE = 3'h6;
    // port select in address bits 5:4
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam logic [1:0] PORT_D = 2'h3;
    // reset values and field positions
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] DRV_OD_MASK_AB = 8'hF0;
    localparam logic [7:0] DRV_OD_MASK_C  = 8'hFF;
    localparam logic [7:0] DRV_SLEW_MASK_AB = 8'h0F;
    localparam logic [7:0] DRV_SLEW_MASK_D  = 8'h07;
    localparam logic [7:0] PORT_D_MASK   = 8'h07;
    localparam int         PMODE_BIT     = 7;
    // host bus flavours for address output
    typedef enum logic [3:0] {
        CIO_BUS_MUX   = 4'b0001,
        CIO_BUS_PAGE  = 4'b0010,
        CIO_BUS_NMUX  = 4'b0100,
        CIO_BUS_OTHER = 4'b1000
    } cio_bus_t;
endpackage : cio_pkg

// >>> hdl/cio_pin_slice.sv
`timescale 1ns/1ns
// one 8-bit port: direction merge, output mux, open drain handling
module cio_pin_slice #(
    parameter int W = 8
) (
    // configuration
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] logic_oe,
    input  wire logic [W-1:0] addr_sel,
    input  wire logic [W-1:0] od_sel,
    // data sources
    input  wire logic [W-1:0] dout,
    input  wire logic [W-1:0] addr_val,
    input  wire logic [W-1:0] logic_out,
    // pin side, before registering
    output logic      [W-1:0] next_o,
    output logic      [W-1:0] next_oe
);
    // per-bit merge; bit n only sees bit n of each source
    always_comb begin
        for (int i = 0; i < W; i++) begin                                     // R12
            next_o[i]  = addr_sel[i] ? addr_val[i] :
                         (logic_oe[i] ? logic_out[i] : dout[i]);              // R22
            next_oe[i] = dir[i] | logic_oe[i] | addr_sel[i];                  // R16
            // open drain: only drive low, let the pull-up make the high
            if (od_sel[i] && next_o[i]) begin                                 // R18
                next_oe[i] = 1'b0;
            end
        end
    end
endmodule : cio_pin_slice

// >>> hdl/cio_capture.sv
`timescale 1ns/1ns
// address input capture on the address latch strobe
module cio_capture #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         clk_en,
    // strobe and pins
    input  wire logic         address_latch_strobe,
    input  wire logic [W-1:0] pin_i,
    // captured value
    output logic      [W-1:0] captured
);
    // latch on the strobe level; transparent-latch feel kept synchronous
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            captured <= '0;
        end else if (clk_en && address_latch_strobe) begin
            captured <= pin_i;                                                // R06
        end
    end
endmodule : cio_capture

// >>> verif/cio_pin_partner.sv
`timescale 1ns/1ns
// far side of the pins: board pull-ups plus an external driver
module cio_pin_partner #(
    parameter int W = 8
) (
    // device side
    input  wire logic [4*W-1:0] pin_o,
    input  wire logic [4*W-1:0] pin_oe,
    // external driver
    input  wire logic [4*W-1:0] ext_val,
    input  wire logic [4*W-1:0] ext_en,
    // level seen at the pins
    output logic      [4*W-1:0] pin_i
);
    // a released pin floats up, which open drain relies on
    always_comb begin
        for (int i = 0; i < 4*W; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule : cio_pin_partner

// >>> verif/cio_port_monitor.sv
`timescale 1ns/1ns
module cio_port_monitor #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic           sys_clk,
    input wire logic           rstn,
    input wire logic           clk_en,
    // register port
    input wire logic [5:0]     reg_addr,
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic [7:0]     reg_wdata,
    input wire logic [7:0]     reg_rdata,
    // bus context
    input wire logic           data_port_en,
    input wire logic           host_data_oe,
    input wire logic [7:0]     host_data_o,
    input wire logic           jtag_en,
    input wire logic [7:0]     jtag_oe,
    input wire logic [4*W-1:0] logic_oe,
    // pins
    input wire logic [4*W-1:0] pin_o,
    input wire logic [4*W-1:0] pin_oe,
    input wire logic [4*W-1:0] pin_fast_slew
);
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    // register port and data port steps
    sequence wr_dir_seq;
        clk_en && reg_wr && reg_addr == 6'h01;
    endsequence
    sequence rd_seq(logic [5:0] a);
        clk_en && reg_rd && !reg_wr && reg_addr == a;
    endsequence
    sequence data_idle_seq;
        (clk_en && data_port_en && !host_data_oe)[*2];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    reset_clear_a:
        assert property (disable iff (1'b0) !rstn |-> pin_oe == '0 && reg_rdata == 8'h00)
        else $error("outputs not clear in reset");
    unmapped_zero_a:
        assert property (clk_en && reg_rd && reg_addr[2:0] == 3'h7 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    portd_dir_a:
        assert property (rd_seq(6'h31) |=> reg_rdata[7:3] == 5'h00)
        else $error("port D direction upper bits set");
    mode_cd_a:
        assert property (rd_seq(6'h20) or rd_seq(6'h30) |=> reg_rdata == 8'h00)
        else $error("mode register seen on port C or D");
    dir_readback_a:
        assert property (wr_dir_seq ##1 (clk_en && !reg_wr) ##1 rd_seq(6'h01)
            |=> reg_rdata == $past(reg_wdata, 3))
        else $error("direction write not read back");
    slew_map_a:
        assert property (pin_fast_slew[31:27] == 5'h00 && pin_fast_slew[23:16] == 8'h00
            && pin_fast_slew[15:12] == 4'h0 && pin_fast_slew[7:4] == 4'h0)
        else $error("fast slew on a pin without slew control");
    logic_oe_a:
        assert property (clk_en |=> (pin_oe[26:24] & $past(logic_oe[26:24]))
            == $past(logic_oe[26:24]))
        else $error("logic enable did not turn the driver on");
    data_port_a:
        assert property (data_idle_seq |-> pin_oe[7:0] == 8'h00)
        else $error("port A driven while data port idle");
    jtag_share_a:
        assert property (clk_en && jtag_en |=> pin_oe[23:16] == $past(jtag_oe))
        else $error("port C enables not from programming port");
    // data port must win over every other port A source, value and enable alike
    data_drive_a:
        assert property (clk_en && data_port_en && host_data_oe
            |=> pin_o[7:0] == $past(host_data_o) && pin_oe[7:0] == 8'hFF)
        else $error("port A not driven from host data");
endmodule : cio_port_monitor

bind cio_port_block cio_port_monitor #(.W(W)) i_mon (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .data_port_en(data_port_en), .host_data_oe(host_data_oe), .jtag_en(jtag_en),
    .host_data_o(host_data_o), .jtag_oe(jtag_oe), .logic_oe(logic_oe),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_fast_slew(pin_fast_slew)
);

// >>> verif/cio_port_block_test.sv
`timescale 1ns/1ns
module cio_port_block_test;
    localparam int W = 8;
    logic        sys_clk, rstn, clk_en, reg_wr, reg_rd, address_latch_strobe, jtag_en;
    logic        data_port_en, host_data_oe, peripheral_select_zero, peripheral_select_one;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, host_data_o, host_data_i, jtag_o, jtag_oe, v;
    logic [3:0]  bus_type;
    logic [15:0] host_addr;
    logic [31:0] logic_oe, logic_out, pin_i, pin_o, pin_oe, pin_fast_slew, ext_val, ext_en, seed;
    logic [1:0]  rd_pipe = 2'b00;
    logic [2:0]  rw_idx[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    int          n_errors, samples_checked;
    string       name_q[$];
    logic [7:0]  exp_q[$];
    cio_port_block #(.W(W)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .bus_type(bus_type), .host_addr(host_addr), .data_port_en(data_port_en),
        .address_latch_strobe(address_latch_strobe), .host_data_o(host_data_o),
        .host_data_oe(host_data_oe), .host_data_i(host_data_i), .jtag_en(jtag_en),
        .peripheral_select_zero(peripheral_select_zero), .jtag_o(jtag_o), .jtag_oe(jtag_oe),
        .peripheral_select_one(peripheral_select_one), .logic_oe(logic_oe),
        .logic_out(logic_out), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_fast_slew(pin_fast_slew)
    );
    cio_pin_partner #(.W(W)) i_far (
        .pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i)
    );
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", what, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic wr(input logic [1:0] p, input logic [2:0] r, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = {p, 1'b0, r};
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] p, input logic [2:0] r, input logic [7:0] e,
                      input string n);
        @(negedge sys_clk);
        reg_addr = {p, 1'b0, r};
        reg_rd = 1'b1;
        exp_q.push_back(e);
        name_q.push_back(n);
        @(negedge sys_clk);
        reg_rd = 1'b0;
    endtask : rd
    // pins trail register state by an edge, so two edges are let pass
    task automatic pins(input logic [1:0] p, input logic [7:0] o, input logic [7:0] oe);
        repeat (2) @(negedge sys_clk);
        chk("pin oe", oe, pin_oe[p*8 +: 8]);
        chk("pin out", o & oe, pin_o[p*8 +: 8] & oe);
    endtask : pins
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    // read data is compared a cycle after it is due, well inside its hold time
    always @(posedge sys_clk) rd_pipe <= {rd_pipe[0], reg_rd & clk_en};
    always @(negedge sys_clk) begin
        if (rd_pipe[1]) begin
            chk(name_q.pop_front(), {24'h0, exp_q.pop_front()}, {24'h0, reg_rdata});
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, clk_en, reg_wr, reg_rd, address_latch_strobe, data_port_en, jtag_en} = '0;
        {host_data_oe, peripheral_select_zero, peripheral_select_one, reg_addr} = '0;
        {reg_wdata, host_data_o, jtag_o, jtag_oe, logic_oe, ext_val, ext_en} = '0;
        {n_errors, samples_checked, host_addr} = '0;
        bus_type = cio_pkg::CIO_BUS_OTHER;
        seed = 32'h70444423;
        logic_out = lfsr(seed);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        clk_en = 1'b1;
        for (int p = 0; p < 4; p++) begin
            for (int r = 0; r < 3; r++) rd(p[1:0], r[2:0], 8'h00, "cfg reset");
        end
        // random register traffic, then direction and output data per port
        for (int p = 0; p < 4; p++) begin
            foreach (rw_idx[k]) begin
                seed = lfsr(seed);
                v = seed[7:0];
                wr(p[1:0], rw_idx[k], v);
                if (rw_idx[k] == cio_pkg::REG_MODE && p > 1) v = 8'h00;
                if (p == 3) v = v & cio_pkg::PORT_D_MASK;
                rd(p[1:0], rw_idx[k], v, "cfg rw");
            end
            seed = lfsr(seed);
            wr(p[1:0], cio_pkg::REG_DRV, 8'h00);
            wr(p[1:0], cio_pkg::REG_MODE, 8'h00);
            wr(p[1:0], cio_pkg::REG_DOUT, seed[7:0]);
            wr(p[1:0], cio_pkg::REG_DIR, seed[15:8]);
            v = (p == 3) ? cio_pkg::PORT_D_MASK : 8'hFF;
            pins(p[1:0], seed[7:0] & v, seed[15:8] & v);
            wr(p[1:0], cio_pkg::REG_DIR, 8'h00);
        end
        clk_en = 1'b0;
        wr(2'h1, cio_pkg::REG_DIR, 8'hFF);
        clk_en = 1'b1;
        rd(2'h1, cio_pkg::REG_DIR, 8'h00, "frozen wr");
        rd(2'h0, 3'h7, 8'h00, "unmapped");
        logic_oe = 32'h0500_3C00;
        repeat (2) @(negedge sys_clk);
        chk("logic oe", 32'h0500_3C00, pin_oe);
        chk("logic out", logic_out & 32'h0500_3C00, pin_o & 32'h0500_3C00);
        logic_oe = '0;
        // open drain on port C, then fast slew where it exists
        wr(2'h2, cio_pkg::REG_DRV, 8'hFF);
        wr(2'h2, cio_pkg::REG_DOUT, 8'h5A);
        wr(2'h2, cio_pkg::REG_DIR, 8'hFF);
        pins(2'h2, 8'h00, 8'hA5);
        rd(2'h2, cio_pkg::REG_DIN, 8'h5A, "od level");
        for (int p = 0; p < 4; p++) wr(p[1:0], cio_pkg::REG_DRV, 8'hFF);
        repeat (2) @(negedge sys_clk);
        chk("slew", 32'h0700_0F0F, pin_fast_slew);
        for (int p = 0; p < 4; p++) wr(p[1:0], cio_pkg::REG_DRV, 8'h00);
        wr(2'h2, cio_pkg::REG_DIR, 8'h00);
        // live levels and strobe capture on an input-only port B
        ext_en = 32'h0000_FF00;
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            ext_val = seed;
            rd(2'h1, cio_pkg::REG_DIN, seed[15:8], "data in");
        end
        @(negedge sys_clk);
        address_latch_strobe = 1'b1;
        v = ext_val[15:8];
        @(negedge sys_clk);
        address_latch_strobe = 1'b0;
        ext_val = ~ext_val;
        rd(2'h1, cio_pkg::REG_CAPT, v, "capture");
        ext_en = '0;
        // latched address out needs mode and direction together
        host_addr = seed[31:16];
        bus_type = cio_pkg::CIO_BUS_MUX;
        wr(2'h0, cio_pkg::REG_MODE, 8'hFF);
        wr(2'h1, cio_pkg::REG_MODE, 8'hFF);
        pins(2'h1, 8'h00, 8'h00);
        wr(2'h0, cio_pkg::REG_DIR, 8'hFF);
        wr(2'h1, cio_pkg::REG_DIR, 8'hFF);
        pins(2'h0, host_addr[7:0], 8'hFF);
        pins(2'h1, host_addr[7:0], 8'hFF);
        bus_type = cio_pkg::CIO_BUS_PAGE;
        pins(2'h1, host_addr[15:8], 8'hFF);
        bus_type = cio_pkg::CIO_BUS_NMUX;
        pins(2'h1, host_addr[7:0], 8'hFF);
        bus_type = cio_pkg::CIO_BUS_OTHER;
        wr(2'h0, cio_pkg::REG_MODE, 8'h00);
        wr(2'h1, cio_pkg::REG_MODE, 8'h00);
        wr(2'h1, cio_pkg::REG_DIR, 8'h00);
        // peripheral buffer on port A, direction bits still all set
        wr(2'h0, cio_pkg::REG_PMODE, 8'h80);
        pins(2'h0, 8'h00, 8'h00);
        host_data_o = seed[7:0];
        host_data_oe = 1'b1;
        peripheral_select_zero = 1'b1;
        pins(2'h0, host_data_o, 8'hFF);
        {host_data_oe, peripheral_select_zero, peripheral_select_one} = 3'b001;
        v = ~host_data_o;
        ext_en = 32'h0000_00FF;
        ext_val = {24'h0, v};
        pins(2'h0, 8'h00, 8'h00);
        chk("bus in", v, host_data_i);
        {peripheral_select_one, ext_en} = '0;
        wr(2'h0, cio_pkg::REG_PMODE, 8'h00);
        data_port_en = 1'b1;
        pins(2'h0, 8'h00, 8'h00);
        host_data_oe = 1'b1;
        pins(2'h0, host_data_o, 8'hFF);
        {data_port_en, host_data_oe, jtag_en, jtag_oe, jtag_o} = {3'b001, 8'h0F, seed[15:8]};
        pins(2'h2, jtag_o, 8'h0F);
        jtag_en = 1'b0;
        pins(2'h2, 8'h00, 8'h00);
        close_out();
    end
endmodule : cio_port_block_test
